// *** design/rhspi_pkg.sv ***
// package for the radio host serial command port
// assumes a 100 MHz system clock sampling a host serial clock of at most 10 MHz
package rhspi_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_MAX_NS = 100;
  localparam int CTS_TYP_NS = 20000;
  localparam int CTS_TYP_CYC = CTS_TYP_NS / CLK_PERIOD_NS;
  localparam int WAIT_W = 12;

  // command codes
  localparam logic [7:0] CMD_QUICK_A = 8'h50;
  localparam logic [7:0] CMD_QUICK_B = 8'h51;
  localparam logic [7:0] CMD_QUICK_C = 8'h53;
  localparam logic [7:0] CMD_QUICK_D = 8'h57;
  localparam logic [7:0] CMD_READ_RESP = 8'h44;
  localparam logic [7:0] CMD_READ_RXBUF = 8'h77;

  // clear-to-send answers
  localparam logic [7:0] CTS_READY = 8'hff;
  localparam logic [7:0] CTS_BUSY = 8'h00;

  // receive buffer
  localparam int RXBUF_DEPTH = 64;
  localparam int RXBUF_AW = 6;
  localparam logic [7:0] EMPTY_BYTE = 8'h00;

  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] BIT_RST = 3'h0;
  localparam logic [1:0] QIDX_RST = 2'h0;

  typedef enum logic [2:0] {
    MODE_CMD = 3'b000,
    MODE_PARAM = 3'b001,
    MODE_QUICK = 3'b010,
    MODE_CTS = 3'b011,
    MODE_RXBUF = 3'b100
  } rhspi_mode_t;

  // four quick status values, a first
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } rhspi_quick_t;

endpackage : rhspi_pkg

// *** design/rhspi_port.sv ***
// serial command port of the radio, device side
// assumes host drives SCLK/SDI/select asynchronously; internal controller on CLK_I
// Overview of operation
// - four wires: host clock, host data in, device data out, low select
// - first byte after select falls is command, then variable parameter bytes
// - input bits sampled on rising serial clock edges, host centres them
// - the response read command answers FFh clear-to-send only once response is ready
// - ready normally shows about 20 us after the command
// - output bits change on falling edges, host captures on next rise
// - received data offered on a general pin and a 64-byte readable buffer
// - four quick values read without poll, circular every eight clocks after the first 8
// - quick values refreshed only while select is high, never mid-transaction
`timescale 1ns/1ps
`default_nettype none
module rhspi_port
  import rhspi_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SCLK_I,
  input wire logic SDI_I,
  input wire logic CHIP_SELECT_N_I,
  output logic SDO_O,
  output logic SDO_OE_O,
  output logic CMD_VALID_O,
  output logic [7:0] CMD_O,
  output logic PARAM_VALID_O,
  output logic [7:0] PARAM_O,
  input wire logic CTRL_READY_I,
  input wire logic [7:0] RESP_I,
  output logic RESP_NEXT_O,
  output logic CTS_LATE_O,
  input wire rhspi_quick_t QUICK_STATUS_VALUE_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_VALID_I,
  output logic RX_READY_O,
  input wire logic RX_BIT_I,
  output logic GPIO_RX_O
);
  function automatic logic is_quick(input logic [7:0] code);
    return code inside {CMD_QUICK_A, CMD_QUICK_B, CMD_QUICK_C, CMD_QUICK_D};
  endfunction : is_quick
  function automatic logic [1:0] quick_idx(input logic [7:0] code);
    logic [1:0] idx;
    idx = 2'h0;
    if (code == CMD_QUICK_B) idx = 2'h1;
    if (code == CMD_QUICK_C) idx = 2'h2;
    if (code == CMD_QUICK_D) idx = 2'h3;
    return idx;
  endfunction : quick_idx
  function automatic logic [7:0] quick_pick(input rhspi_quick_t q, input logic [1:0] idx);
    logic [7:0] v;
    case (idx)
      2'h0: v = q.a;
      2'h1: v = q.b;
      2'h2: v = q.c;
      default: v = q.d;
    endcase
    return v;
  endfunction : quick_pick
  logic sclk_s1, sclk_s2, sclk_s3, sdi_s1, sdi_s2, cs_s1, cs_s2;
  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;
  rhspi_mode_t mode_reg, mode_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] rx_shift_reg, rx_shift_next, tx_reg, tx_next;
  logic sdo_reg, sdo_next, oe_reg, oe_next, cts_ok_reg, cts_ok_next;
  logic [1:0] qidx_reg, qidx_next;
  rhspi_quick_t snap_reg, snap_next;
  logic cmd_v_reg, cmd_v_next, par_v_reg, par_v_next, resp_nx_reg, resp_nx_next;
  logic [7:0] cmd_reg, cmd_next, par_reg, par_next;
  logic waiting_reg, waiting_next, late_reg, late_next;
  logic [WAIT_W-1:0] wait_reg, wait_next;
  logic gpio_reg, gpio_next;
  logic [7:0] rx_mem [RXBUF_DEPTH];
  logic [RXBUF_AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [RXBUF_AW:0] fill_reg, fill_next;
  logic push, pop, full, empty;
  logic [7:0] shifted, rx_head;
  assign full = (fill_reg == (RXBUF_AW+1)'(RXBUF_DEPTH));
  assign empty = (fill_reg == '0);
  assign push = RX_VALID_I & ~full;
  assign rx_head = empty ? EMPTY_BYTE : rx_mem[rd_ptr_reg];
  assign shifted = {rx_shift_reg[6:0], sdi_s2};
  always_comb
  begin
    mode_next = mode_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_shift_next = rx_shift_reg;
    tx_next = tx_reg;
    sdo_next = sdo_reg;
    oe_next = ~cs_s2;
    cts_ok_next = cts_ok_reg;
    qidx_next = qidx_reg;
    snap_next = snap_reg;
    cmd_v_next = 1'b0;
    cmd_next = cmd_reg;
    par_v_next = 1'b0;
    par_next = par_reg;
    resp_nx_next = 1'b0;
    pop = 1'b0;
    waiting_next = waiting_reg & ~CTRL_READY_I;
    wait_next = wait_reg;
    late_next = late_reg;
    gpio_next = RX_BIT_I;
    if (waiting_reg && !CTRL_READY_I)
    begin
      if (wait_reg == WAIT_W'(CTS_TYP_CYC - 1))
      begin
        late_next = 1'b1;
        waiting_next = 1'b0;
      end
      wait_next = wait_reg + WAIT_W'(1);
    end
    if (cs_s2)
    begin
      mode_next = MODE_CMD;
      bit_cnt_next = BIT_RST;
      tx_next = BYTE_RST;
      cts_ok_next = 1'b0;
      snap_next = QUICK_STATUS_VALUE_I;
    end
    else if (sclk_fall)
    begin
      sdo_next = tx_reg[7];
      tx_next = {tx_reg[6:0], 1'b0};
    end
    else if (sclk_rise)
    begin
      rx_shift_next = shifted;
      bit_cnt_next = bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7)
      begin
        case (mode_reg)
          MODE_CMD:
          begin
            cmd_v_next = 1'b1;
            cmd_next = shifted;
            waiting_next = 1'b1;
            wait_next = '0;
            late_next = 1'b0;
            if (is_quick(shifted))
            begin
              mode_next = MODE_QUICK;
              tx_next = quick_pick(snap_reg, quick_idx(shifted));
              qidx_next = quick_idx(shifted) + 2'h1;
            end
            else if (shifted == CMD_READ_RESP)
            begin
              mode_next = MODE_CTS;
              tx_next = CTRL_READY_I ? CTS_READY : CTS_BUSY;
              cts_ok_next = CTRL_READY_I;
            end
            else if (shifted == CMD_READ_RXBUF)
            begin
              mode_next = MODE_RXBUF;
              tx_next = rx_head;
              pop = ~empty;
            end
            else
              mode_next = MODE_PARAM;
          end
          MODE_QUICK:
          begin
            tx_next = quick_pick(snap_reg, qidx_reg);
            qidx_next = qidx_reg + 2'h1;
          end
          MODE_CTS:
          begin
            tx_next = cts_ok_reg ? RESP_I : BYTE_RST;
            resp_nx_next = cts_ok_reg;
          end
          MODE_RXBUF:
          begin
            tx_next = rx_head;
            pop = ~empty;
          end
          MODE_PARAM:
          begin
            par_v_next = 1'b1;
            par_next = shifted;
          end
          default: mode_next = MODE_CMD;
        endcase
      end
    end
    wr_ptr_next = push ? wr_ptr_reg + RXBUF_AW'(1) : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + RXBUF_AW'(1) : rd_ptr_reg;
    fill_next = fill_reg + (RXBUF_AW+1)'(push) - (RXBUF_AW+1)'(pop);
  end
  always_ff @(posedge CLK_I)
  begin
    if (push)
      rx_mem[wr_ptr_reg] <= RX_DATA_I;
    if (RST_I)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      mode_reg <= MODE_CMD;
      bit_cnt_reg <= BIT_RST;
      rx_shift_reg <= BYTE_RST;
      tx_reg <= BYTE_RST;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      cts_ok_reg <= 1'b0;
      qidx_reg <= QIDX_RST;
      snap_reg <= '0;
      cmd_v_reg <= 1'b0;
      cmd_reg <= BYTE_RST;
      par_v_reg <= 1'b0;
      par_reg <= BYTE_RST;
      resp_nx_reg <= 1'b0;
      waiting_reg <= 1'b0;
      wait_reg <= '0;
      late_reg <= 1'b0;
      gpio_reg <= 1'b0;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      fill_reg <= '0;
    end
    else
    begin
      sclk_s1 <= SCLK_I;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sdi_s1 <= SDI_I;
      sdi_s2 <= sdi_s1;
      cs_s1 <= CHIP_SELECT_N_I;
      cs_s2 <= cs_s1;
      mode_reg <= mode_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_shift_reg <= rx_shift_next;
      tx_reg <= tx_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      cts_ok_reg <= cts_ok_next;
      qidx_reg <= qidx_next;
      snap_reg <= snap_next;
      cmd_v_reg <= cmd_v_next;
      cmd_reg <= cmd_next;
      par_v_reg <= par_v_next;
      par_reg <= par_next;
      resp_nx_reg <= resp_nx_next;
      waiting_reg <= waiting_next;
      wait_reg <= wait_next;
      late_reg <= late_next;
      gpio_reg <= gpio_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      fill_reg <= fill_next;
    end
  end
  assign SDO_O = sdo_reg;
  assign SDO_OE_O = oe_reg;
  assign CMD_VALID_O = cmd_v_reg;
  assign CMD_O = cmd_reg;
  assign PARAM_VALID_O = par_v_reg;
  assign PARAM_O = par_reg;
  assign RESP_NEXT_O = resp_nx_reg;
  assign CTS_LATE_O = late_reg;
  assign RX_READY_O = ~full;
  assign GPIO_RX_O = gpio_reg;
  sdo_float_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    cs_s2 |=> !SDO_OE_O) else $error("data output driven while deselected");
  cmd_first_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    CMD_VALID_O |-> $past(mode_reg) == MODE_CMD && $past(bit_cnt_reg) == 3'h7)
    else $error("command strobe not on first byte");
  rise_sample_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $changed(rx_shift_reg) |-> $past(sclk_rise)) else $error("input shifted off a rise");
  fall_change_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $changed(SDO_O) |-> $past(sclk_fall)) else $error("output changed off a fall");
  cts_value_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (sclk_rise && !cs_s2 && bit_cnt_reg == 3'h7 && mode_reg == MODE_CMD &&
     shifted == CMD_READ_RESP) |=> tx_reg == ($past(CTRL_READY_I) ? CTS_READY : CTS_BUSY))
    else $error("clear-to-send value wrong");
  quick_order_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (sclk_rise && !cs_s2 && bit_cnt_reg == 3'h7 && mode_reg == MODE_QUICK) |=>
    tx_reg == quick_pick(snap_reg, $past(qidx_reg)) && qidx_reg == $past(qidx_reg) + 2'h1)
    else $error("quick value order wrong");
  snap_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!cs_s2 && $past(!cs_s2)) |-> $stable(snap_reg)) else $error("quick values moved mid-frame");
  cts_late_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(CTS_LATE_O) |-> $past(wait_reg) == WAIT_W'(CTS_TYP_CYC - 1))
    else $error("late flag at wrong count");
endmodule : rhspi_port
`default_nettype wire

// *** testbench/rhspi_host_model.sv ***
// host serial master model for the radio command port
// assumes the bench clock paces every pin change
`timescale 1ns/1ps
`default_nettype none
module rhspi_host_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic sdi_o,
  output logic cs_n_o
);
  initial
  begin
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    cs_n_o = 1'b1;
  end
  task open();
    @(posedge clk_i) cs_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask : open
  task close();
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (10) @(posedge clk_i);
  endtask : close
  // msb first, 12 or 13 cycle bits keep the link near 8 MHz
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sdi_o <= tx[i];
      repeat (6) @(posedge clk_i);
      sclk_o <= 1'b1;
      rx[i] = sdo_i;
      repeat (6 + i % 2) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
  endtask : xfer
endmodule : rhspi_host_model
`default_nettype wire

// *** testbench/radio_host_spi_command_port_test.sv ***
// self-checking bench for the radio host serial command port
// assumes rhspi_pkg, rhspi_port and the host model compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module radio_host_spi_command_port_test
  import rhspi_pkg::*;
;
  logic clk = 0, rst = 1, sclk, sdi, cs_n, sdo, oe, cmd_v, par_v, ready = 0;
  logic resp_next, cts_late, rx_valid = 0, rx_ready, rx_bit = 0, gpio, sdo_last = 0;
  logic [7:0] cmd, par, resp = 8'h5a, rx_data = 8'h00, b, b2, b3;
  wire logic sdo_line;
  rhspi_quick_t quick = {8'h11, 8'h22, 8'h33, 8'h44};
  int failures = 0, checks_done = 0, n_cmd = 0, n_par = 0, cycles = 0;
  always #5 clk = ~clk;
  // released output shows the inverse of its last level
  assign sdo_line = oe ? sdo : ~sdo_last;
  always @(posedge clk)
  begin
    cycles++;
    n_cmd += (cmd_v === 1'b1);
    n_par += (par_v === 1'b1);
    if (resp_next === 1'b1)
      resp <= resp + 8'h01;
    if (oe === 1'b1)
      sdo_last <= sdo;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end
  rhspi_port uut (.CLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .SDI_I(sdi),
    .CHIP_SELECT_N_I(cs_n), .SDO_O(sdo), .SDO_OE_O(oe), .CMD_VALID_O(cmd_v),
    .CMD_O(cmd), .PARAM_VALID_O(par_v), .PARAM_O(par), .CTRL_READY_I(ready),
    .RESP_I(resp), .RESP_NEXT_O(resp_next), .CTS_LATE_O(cts_late),
    .QUICK_STATUS_VALUE_I(quick), .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid),
    .RX_READY_O(rx_ready), .RX_BIT_I(rx_bit), .GPIO_RX_O(gpio));
  rhspi_host_model host (.clk_i(clk), .sdo_i(sdo_line), .sclk_o(sclk), .sdi_o(sdi),
    .cs_n_o(cs_n));
  task t_reset();
    `CHK("oe", 1'b0, oe)
    `CHK("cmd", BYTE_RST, cmd)
    `CHK("late", 1'b0, cts_late)
    `CHK("rx_ready", 1'b1, rx_ready)
  endtask : t_reset
  task t_write();
    host.open();
    #1 `CHK("oe_on", 1'b1, oe)
    host.xfer(8'h12, b);
    `CHK("first", 8'h00, b)
    host.xfer(8'ha5, b);
    host.xfer(8'h3c, b);
    host.close();
    `CHK("cmd", 8'h12, cmd)
    `CHK("n_cmd", 1, n_cmd)
    `CHK("par", 8'h3c, par)
    `CHK("n_par", 2, n_par)
    `CHK("oe_off", 1'b0, oe)
  endtask : t_write
  task t_cts();
    host.open();
    host.xfer(CMD_READ_RESP, b);
    host.xfer(8'h00, b);
    host.close();
    `CHK("busy", CTS_BUSY, b)
    repeat (2100) @(posedge clk);
    #1 `CHK("late", 1'b1, cts_late)
    @(posedge clk) ready <= 1'b1;
    // poll again in a fresh frame
    host.open();
    host.xfer(CMD_READ_RESP, b);
    host.xfer(8'h00, b);
    host.xfer(8'h00, b2);
    host.xfer(8'h00, b3);
    host.close();
    `CHK("ready", CTS_READY, b)
    `CHK("resp0", 8'h5a, b2)
    `CHK("resp1", 8'h5b, b3)
    `CHK("late_clr", 1'b0, cts_late)
  endtask : t_cts
  task t_quick();
    logic [7:0] nv [4];
    logic [7:0] code [4];
    nv = '{8'h55, 8'h66, 8'h77, 8'h88};
    code = '{CMD_QUICK_A, CMD_QUICK_B, CMD_QUICK_C, CMD_QUICK_D};
    host.open();
    host.xfer(CMD_QUICK_A, b);
    host.xfer(8'h00, b);
    @(posedge clk) quick <= {8'h55, 8'h66, 8'h77, 8'h88};
    host.xfer(8'h00, b2);
    host.xfer(8'h00, b3);
    host.close();
    `CHK("qa", 8'h11, b)
    `CHK("qb", 8'h22, b2)
    `CHK("frozen", 8'h33, b3)
    for (int k = 0; k < 4; k++)
    begin
      host.open();
      host.xfer(code[k], b);
      for (int j = 0; j < 5; j++)
      begin
        host.xfer(8'h00, b);
        `CHK("quick", nv[(k + j) % 4], b)
      end
      host.close();
    end
  endtask : t_quick
  task t_rxbuf();
    @(posedge clk)
    begin
      rx_valid <= 1'b1;
      rx_data <= 8'h01;
    end
    for (int i = 1; i <= 66; i++)
    begin
      @(posedge clk);
      rx_data <= 8'(i + 1);
    end
    rx_valid <= 1'b0;
    #1 `CHK("full", 1'b0, rx_ready)
    host.open();
    host.xfer(CMD_READ_RXBUF, b);
    for (int i = 1; i <= 65; i++)
    begin
      host.xfer(8'h00, b);
      `CHK("rxbuf", (i <= 64) ? 8'(i) : EMPTY_BYTE, b)
    end
    host.close();
    `CHK("drained", 1'b1, rx_ready)
    @(posedge clk) rx_bit <= 1'b1;
    #1 `CHK("gpio0", 1'b0, gpio)
    @(posedge clk);
    #1 `CHK("gpio1", 1'b1, gpio)
  endtask : t_rxbuf
  task conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (3) @(posedge clk);
    #1 t_reset();
    @(posedge clk) rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_write();
    t_cts();
    t_quick();
    t_rxbuf();
    conclude();
  end
endmodule : radio_host_spi_command_port_test
`default_nettype wire
